// file: design/dsg_get_unit.sv
// dynamic stream read execution unit with apb register access
//
// Overview of operation
// - link chosen by four index bits per run
// - permitted run loads link word into result
// - non-blocking never stalls, carry shows absence
// - tag mismatch against control bit flags error
// - error flag only when word present too
// - exception variant records cause zero, index
// - stream exception keeps result, fills data reg
// - exception bit ignored unless configuration enables
// - test variants never raise accept
// - atomic variants hold off interrupts
// - blocking stall; interrupts served unless atomic
// - user mode under memory management faults
// - one cycle, or two with small area
// - exists only with links and extended ops
`timescale 1ns/10ps
`default_nettype none
module dsg_get_unit
  import dsg_pkg::*;
#(
  parameter int cfg_link_count            = 16,
  parameter int cfg_extended_link_ops     = 1,
  parameter int cfg_link_exception_enable = 1,
  parameter int cfg_memory_mgmt           = 1,
  parameter int cfg_allow_user_priv_ops   = 0,
  parameter int cfg_small_area            = 0
) (
  // clock and reset
  input  wire logic                      sys_clk_in,
  input  wire logic                      resetn_in,
  // apb slave
  input  wire logic [ADDR_W-1:0]         paddr_in,
  input  wire logic                      psel_in,
  input  wire logic                      penable_in,
  input  wire logic                      pwrite_in,
  input  wire logic [DATA_W-1:0]         pwdata_in,
  output logic [DATA_W-1:0]              prdata_out,
  output logic                           pready_out,
  output logic                           pslverr_out,
  // stream links
  input  wire dsg_link_t [LINK_MAX-1:0]  link_in,
  output logic [LINK_MAX-1:0]            link_accept_out,
  // core side
  input  wire logic                      interrupt_req_in,
  output logic                           interrupt_hold_out,
  output logic                           exception_out
);

  // ==========================================================
  // configuration
  localparam bit IMPL = (cfg_link_count > 0)
                        && (cfg_extended_link_ops == 1);
  localparam bit EXC_ON = (cfg_link_exception_enable == 1);
  localparam bit PRIV_ON = (cfg_memory_mgmt >= 1)
                           && (cfg_allow_user_priv_ops != 1);
  localparam int LAT = (cfg_small_area != 0) ? LAT_SMALL : LAT_FAST;

  // ==========================================================
  // address decode
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == OFS_ISSUE) || (a == OFS_INDEX) || (a == OFS_MSR)
                || (a == OFS_ESR) || (a == OFS_EDR)
                || (a == OFS_RESULT) || (a == OFS_STATUS);
  endfunction

  // ==========================================================
  // state
  dsg_state_t             state;
  dsg_op_t                op;
  logic [IDX_W-1:0]       cur_idx;
  logic [DATA_W-1:0]      index_operand_register;
  logic [DATA_W-1:0]      result_word;
  logic [DATA_W-1:0]      exception_data_reg;
  logic [EC_W-1:0]        exception_cause_field;
  logic [IDX_W-1:0]       exception_specific_field;
  logic                   carry_flag;
  logic                   stream_error_flag;
  logic                   user_privilege_bit;
  logic                   abort_flag;

  // ==========================================================
  // internal nets
  logic                   wr_stb;
  logic                   refuse;
  logic [DATA_W-1:0]      rdata;
  dsg_link_t              sel;
  logic [LINK_MAX-1:0]    sel_onehot;
  logic                   issue_wr;
  logic                   in_eval;
  logic                   priv_fault;
  logic                   present;
  logic                   mismatch;
  logic                   stream_exc;
  logic                   finish;
  logic                   abort;
  logic                   next_accept;

  // ==========================================================
  // apb handshake
  dsg_apb_port u_apb (
    .sys_clk_in  (sys_clk_in),
    .resetn_in   (resetn_in),
    .psel_in     (psel_in),
    .penable_in  (penable_in),
    .pwrite_in   (pwrite_in),
    .pready_out  (pready_out),
    .pslverr_out (pslverr_out),
    .prdata_out  (prdata_out),
    .rdata_in    (rdata),
    .refuse_in   (refuse),
    .wr_stb_out  (wr_stb)
  );

  // issue while busy or when absent is refused
  always_comb begin
    refuse = !is_mapped(paddr_in);
    if (pwrite_in && (paddr_in == OFS_ISSUE)) begin
      refuse = (state != S_IDLE) || !IMPL;
    end
  end

  always_comb begin
    rdata = WORD_RST;
    unique case (paddr_in)
      OFS_INDEX:  rdata = index_operand_register;
      OFS_MSR: begin
        rdata[MSR_CARRY] = carry_flag;
        rdata[MSR_SERR]  = stream_error_flag;
        rdata[MSR_USER]  = user_privilege_bit;
      end
      OFS_ESR: begin
        rdata[ESR_EC_LSB +: EC_W]   = exception_cause_field;
        rdata[ESR_ESS_LSB +: IDX_W] = exception_specific_field;
      end
      OFS_EDR:    rdata = exception_data_reg;
      OFS_RESULT: rdata = result_word;
      OFS_STATUS: begin
        rdata[STS_BUSY]   = (state != S_IDLE);
        rdata[STS_STALL]  = in_eval && !finish;
        rdata[STS_HOLD]   = interrupt_hold_out;
        rdata[STS_ABORT]  = abort_flag;
        rdata[STS_UNIMPL] = !IMPL;
      end
      default:    rdata = WORD_RST;
    endcase
  end

  assign issue_wr = wr_stb && (paddr_in == OFS_ISSUE);

  // ==========================================================
  // link selection
  dsg_link_sel #(
    .LINKS (cfg_link_count)
  ) u_sel (
    .link_in    (link_in),
    .idx_in     (cur_idx),
    .sel_out    (sel),
    .onehot_out (sel_onehot)
  );

  // ==========================================================
  // evaluation terms
  always_comb begin
    in_eval    = (state == S_EXEC);
    priv_fault = PRIV_ON && user_privilege_bit;
    present    = sel.valid;
    mismatch   = present && (sel.last != op.ctrl);
    stream_exc = !priv_fault && mismatch && op.exc && EXC_ON;
    // blocking variants wait for a word
    finish     = in_eval && (priv_fault || present || op.nonblock);
    abort      = in_eval && !finish && interrupt_req_in
                 && !op.atom;
    next_accept = finish && present && !priv_fault
                  && !op.test;
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= S_IDLE;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (issue_wr) begin
            state <= (LAT == LAT_SMALL) ? S_WAIT : S_EXEC;
          end
        end
        S_WAIT: begin
          state <= S_EXEC;
        end
        S_EXEC: begin
          if (abort) begin
            state <= S_IDLE;
          end else if (finish) begin
            state <= next_accept ? S_ACK : S_IDLE;
          end
        end
        S_ACK: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // operand capture at issue
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      op      <= '0;
      cur_idx <= IDX_RST;
    end else if (issue_wr) begin
      op.nonblock <= pwdata_in[ISS_NB];
      op.ctrl     <= pwdata_in[ISS_CTRL];
      op.test     <= pwdata_in[ISS_TEST];
      op.atom     <= pwdata_in[ISS_ATOM];
      op.exc      <= pwdata_in[ISS_EXC];
      cur_idx     <= index_operand_register[IDX_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      index_operand_register <= WORD_RST;
    end else if (wr_stb && (paddr_in == OFS_INDEX)) begin
      index_operand_register <= pwdata_in;
    end
  end

  // ==========================================================
  // link accept, one cycle after the decision
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      link_accept_out <= '0;
    end else begin
      link_accept_out <= next_accept ? sel_onehot : '0;
    end
  end

  // ==========================================================
  // destination
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      result_word <= WORD_RST;
    end else if (finish && !priv_fault && !stream_exc) begin
      result_word <= sel.data;
    end
  end

  // ==========================================================
  // machine status: instruction beats software
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      carry_flag         <= 1'b0;
      user_privilege_bit <= 1'b0;
    end else begin
      if (wr_stb && (paddr_in == OFS_MSR)) begin
        user_privilege_bit <= pwdata_in[MSR_USER];
      end
      if (finish && !priv_fault && op.nonblock) begin
        carry_flag <= !present;
      end else if (wr_stb && (paddr_in == OFS_MSR)) begin
        carry_flag <= pwdata_in[MSR_CARRY];
      end
    end
  end

  // sticky error, set wins over a clearing write
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      stream_error_flag <= 1'b0;
    end else if (finish && !priv_fault && mismatch) begin
      stream_error_flag <= 1'b1;
    end else if (wr_stb && (paddr_in == OFS_MSR)) begin
      stream_error_flag <= pwdata_in[MSR_SERR];
    end
  end

  // ==========================================================
  // exception records
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      exception_cause_field    <= EC_RST;
      exception_specific_field <= IDX_RST;
      exception_data_reg       <= WORD_RST;
    end else if (finish && priv_fault) begin
      exception_cause_field <= EC_PRIV;
    end else if (finish && stream_exc) begin
      exception_cause_field    <= EC_STREAM;
      exception_specific_field <= cur_idx;
      exception_data_reg       <= sel.data;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      exception_out <= 1'b0;
    end else begin
      exception_out <= finish && (priv_fault || stream_exc);
    end
  end

  // ==========================================================
  // interrupt hold and stall abort
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      interrupt_hold_out <= 1'b0;
    end else if (issue_wr) begin
      interrupt_hold_out <= pwdata_in[ISS_ATOM];
    end else if (exception_out) begin
      interrupt_hold_out <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      abort_flag <= 1'b0;
    end else if (issue_wr) begin
      abort_flag <= 1'b0;
    end else if (abort) begin
      abort_flag <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// file: design/dsg_pkg.sv
// shared constants and types of the dynamic stream read unit
`default_nettype none
package dsg_pkg;

  // ==========================================================
  // widths
  localparam int DATA_W   = 32;
  localparam int LINK_MAX = 16;
  localparam int IDX_W    = 4;
  localparam int ADDR_W   = 8;
  localparam int EC_W     = 5;

  // ==========================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_ISSUE  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_INDEX  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MSR    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_ESR    = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_EDR    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;

  // ==========================================================
  // field positions
  localparam int ISS_NB   = 0;
  localparam int ISS_CTRL = 1;
  localparam int ISS_TEST = 2;
  localparam int ISS_ATOM = 3;
  localparam int ISS_EXC  = 4;

  localparam int MSR_CARRY = 0;
  localparam int MSR_SERR  = 1;
  localparam int MSR_USER  = 2;

  localparam int ESR_EC_LSB  = 0;
  localparam int ESR_ESS_LSB = 5;

  localparam int STS_BUSY   = 0;
  localparam int STS_STALL  = 1;
  localparam int STS_HOLD   = 2;
  localparam int STS_ABORT  = 3;
  localparam int STS_UNIMPL = 4;

  // ==========================================================
  // cause codes and reset values
  localparam logic [EC_W-1:0]   EC_STREAM = 5'h00;
  localparam logic [EC_W-1:0]   EC_PRIV   = 5'h07;
  localparam logic [DATA_W-1:0] WORD_RST  = 32'h0000_0000;
  localparam logic [IDX_W-1:0]  IDX_RST   = 4'h0;
  localparam logic [EC_W-1:0]   EC_RST    = 5'h00;

  // ==========================================================
  // cycle counts
  localparam int LAT_FAST  = 1;
  localparam int LAT_SMALL = 2;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_WAIT = 2'b01,
    S_EXEC = 2'b10,
    S_ACK  = 2'b11
  } dsg_state_t;

  typedef struct packed {
    logic              valid;
    logic              last;
    logic [DATA_W-1:0] data;
  } dsg_link_t;

  typedef struct packed {
    logic atom;
    logic exc;
    logic test;
    logic ctrl;
    logic nonblock;
  } dsg_op_t;

endpackage
`default_nettype wire

// file: design/dsg_link_sel.sv
// link selection by index and one-hot accept decode
`timescale 1ns/10ps
`default_nettype none
module dsg_link_sel
  import dsg_pkg::*;
#(
  parameter int LINKS = LINK_MAX
) (
  // links
  input  wire dsg_link_t [LINK_MAX-1:0] link_in,
  // selection
  input  wire logic [IDX_W-1:0]         idx_in,
  output dsg_link_t                     sel_out,
  output logic [LINK_MAX-1:0]           onehot_out
);

  // ==========================================================
  // selection
  logic [LINK_MAX-1:0] fitted;

  genvar gi;
  generate
    for (gi = 0; gi < LINK_MAX; gi++) begin : g_link
      assign fitted[gi]     = (gi < LINKS);
      assign onehot_out[gi] = fitted[gi] && (idx_in == IDX_W'(gi));
    end
  endgenerate

  // unfitted links never show a word
  always_comb begin
    sel_out       = link_in[idx_in];
    sel_out.valid = link_in[idx_in].valid && fitted[idx_in];
  end

endmodule
`default_nettype wire

// file: design/dsg_apb_port.sv
// apb slave handshake with one wait-free access phase
`timescale 1ns/10ps
`default_nettype none
module dsg_apb_port
  import dsg_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              resetn_in,
  // apb
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  output logic                   pready_out,
  output logic                   pslverr_out,
  output logic [DATA_W-1:0]      prdata_out,
  // register side
  input  wire logic [DATA_W-1:0] rdata_in,
  input  wire logic              refuse_in,
  output logic                   wr_stb_out
);

  // ==========================================================
  // answer is loaded in the setup cycle
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= WORD_RST;
    end else begin
      pready_out  <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && refuse_in;
      if (psel_in && !penable_in) begin
        prdata_out <= pwrite_in ? WORD_RST : rdata_in;
      end
    end
  end

  // refused writes have no effect
  assign wr_stb_out = psel_in && penable_in && pready_out && pwrite_in
                      && !pslverr_out;

endmodule
`default_nettype wire

// file: verif/dsg_link_model.sv
// stream master model driving the link inputs
`timescale 1ns/10ps
`default_nettype none
module dsg_link_model
  import dsg_pkg::*;
(
  // clock and reset
  input  wire logic                sys_clk_in,
  input  wire logic                resetn_in,
  // links
  input  wire logic [LINK_MAX-1:0] accept_in,
  output dsg_link_t [LINK_MAX-1:0] link_out
);
  // word held until taken, then inverted so stale data never matches
  always @(posedge sys_clk_in) begin
    for (int i = 0; i < LINK_MAX; i++) begin
      if (!resetn_in) begin
        link_out[i] <= '0;
      end else if (accept_in[i] && link_out[i].valid) begin
        link_out[i] <= '{1'b0, ~link_out[i].last, ~link_out[i].data};
      end
    end
  end
  task automatic offer(input int i, input logic [DATA_W-1:0] d, input logic l, input int dly);
    repeat (dly) @(posedge sys_clk_in);
    link_out[i] <= '{1'b1, l, d};
  endtask
endmodule
`default_nettype wire

// file: verif/dsg_get_unit_asserts.sv
// port checks of the dynamic stream read unit
`timescale 1ns/10ps
`default_nettype none
module dsg_get_unit_asserts
  import dsg_pkg::*;
(
  // clock and reset
  input  wire logic                     sys_clk_in,
  input  wire logic                     resetn_in,
  // apb
  input  wire logic [ADDR_W-1:0]        paddr_in,
  input  wire logic                     psel_in,
  input  wire logic                     penable_in,
  input  wire logic                     pwrite_in,
  input  wire logic [DATA_W-1:0]        pwdata_in,
  input  wire logic                     pready_out,
  input  wire logic                     pslverr_out,
  // links and core
  input  wire dsg_link_t [LINK_MAX-1:0] link_in,
  input  wire logic [LINK_MAX-1:0]      link_accept_out,
  input  wire logic                     interrupt_hold_out,
  input  wire logic                     exception_out
);
  // ==========================================
  // helper state
  logic [IDX_W-1:0]    idx;
  logic                usr;
  logic                ctl;
  logic                wr_ok;
  logic                issue;
  logic                go_nb;
  logic                peek;
  logic                atom_go;
  logic                none_acc;
  logic [LINK_MAX-1:0] vld;
  logic [LINK_MAX-1:0] lst;
  assign wr_ok = psel_in && penable_in && pready_out && pwrite_in && !pslverr_out;
  assign issue = wr_ok && paddr_in == OFS_ISSUE;
  assign go_nb = issue && pwdata_in[ISS_NB] && !pwdata_in[ISS_TEST] && !usr;
  assign peek = issue && pwdata_in[ISS_TEST];
  assign atom_go = issue && pwdata_in[ISS_ATOM];
  assign none_acc = (link_accept_out == '0);
  always_comb begin
    for (int i = 0; i < LINK_MAX; i++) begin
      vld[i] = link_in[i].valid;
      lst[i] = link_in[i].last;
    end
  end
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      idx <= IDX_RST;
      usr <= 1'b0;
      ctl <= 1'b0;
    end else begin
      if (wr_ok && paddr_in == OFS_INDEX) idx <= pwdata_in[IDX_W-1:0];
      if (wr_ok && paddr_in == OFS_MSR) usr <= pwdata_in[MSR_USER];
      if (issue) ctl <= pwdata_in[ISS_CTRL];
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  // ==========================================
  // sequences
  sequence s_nb_hit;
    go_nb ##1 vld[idx];
  endsequence
  sequence s_exc_hit;
    go_nb && pwdata_in[ISS_EXC] ##1 vld[idx] && lst[idx] != ctl;
  endsequence
  // ==========================================
  // assertions
  a_accept_onehot: assert property ($onehot0(link_accept_out))
    else $error("accept not one-hot");
  a_accept_pulse: assert property (|link_accept_out |=> link_accept_out == '0)
    else $error("accept longer than one cycle");
  a_accept_valid: assert property (|link_accept_out |-> (link_accept_out & ~vld) == '0)
    else $error("accept without valid word");
  a_nb_take: assert property (s_nb_hit |-> ##1 link_accept_out == 16'h0001 << idx)
    else $error("selected word not taken on time");
  a_nb_empty: assert property (go_nb ##1 !vld[idx] |-> ##1 link_accept_out == '0)
    else $error("accept on empty link");
  a_test_quiet: assert property (peek |=> none_acc [*3])
    else $error("test variant consumed a word");
  a_priv_fault: assert property (issue && usr |-> ##2 exception_out && none_acc)
    else $error("user mode issue not faulted");
  a_exc_raise: assert property (s_exc_hit |-> ##1 exception_out)
    else $error("tag mismatch exception missing");
  a_exc_pulse: assert property (exception_out |=> !exception_out)
    else $error("exception pulse too long");
  a_hold_atomic: assert property (atom_go |-> ##[1:2] interrupt_hold_out)
    else $error("atomic issue did not hold interrupts");
endmodule
bind dsg_get_unit dsg_get_unit_asserts u_chk (.sys_clk_in, .resetn_in, .paddr_in, .psel_in,
  .penable_in, .pwrite_in, .pwdata_in, .pready_out, .pslverr_out, .link_in, .link_accept_out,
  .interrupt_hold_out, .exception_out);
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench of the dynamic stream read unit
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import dsg_pkg::*;
  localparam logic [DATA_W-1:0] NB = 32'h1 << ISS_NB, CT = 32'h1 << ISS_CTRL;
  localparam logic [DATA_W-1:0] TS = 32'h1 << ISS_TEST, AT = 32'h1 << ISS_ATOM;
  localparam logic [DATA_W-1:0] EX = 32'h1 << ISS_EXC, CY = 32'h1 << MSR_CARRY;
  localparam logic [DATA_W-1:0] SE = 32'h1 << MSR_SERR;
  logic                     sys_clk, resetn, psel, penable, pwrite, irq;
  logic                     pready, pslverr, hold, exc, perr;
  logic [ADDR_W-1:0]        paddr;
  logic [DATA_W-1:0]        pwdata, prdata, rd, keep;
  logic [LINK_MAX-1:0]      acc;
  dsg_link_t [LINK_MAX-1:0] links;
  int                       num_errors, comparisons;
  int                       exc_count = 0;

  dsg_get_unit dut (.sys_clk_in(sys_clk), .resetn_in(resetn), .paddr_in(paddr), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .link_in(links), .link_accept_out(acc),
    .interrupt_req_in(irq), .interrupt_hold_out(hold), .exception_out(exc));
  dsg_link_model far (.sys_clk_in(sys_clk), .resetn_in(resetn), .accept_in(acc), .link_out(links));

  // exception pulses seen on the core side
  always @(posedge sys_clk) begin
    if (exc === 1'b1) exc_count++;
  end

  // ==========================================
  // tasks
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask
  task automatic xfer(input logic [ADDR_W-1:0] a, input logic w, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    check_bit(pready, 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic expect_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m,
                            input logic [DATA_W-1:0] e);
    xfer(a, 1'b0, '0);
    check(rd & m, e);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      xfer(OFS_STATUS, 1'b0, '0);
      n++;
    end while (rd[STS_BUSY] !== 1'b0 && n < 200);
    check_bit(rd[STS_BUSY], 1'b0);
  endtask
  task automatic run(input int link, input logic [DATA_W-1:0] op);
    xfer(OFS_INDEX, 1'b1, 32'hffff_fff0 | link);
    xfer(OFS_ISSUE, 1'b1, op);
    wait_idle();
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================
  // clock, watchdog, tests
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    #100000;
    num_errors++;
    conclude();
  end
  initial begin
    {resetn, psel, penable, pwrite, irq} = '0;
    paddr = '0;
    pwdata = '0;
    num_errors = 0;
    comparisons = 0;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int a = 4; a <= 24; a += 4) expect_reg(ADDR_W'(a), '1, '0);
    far.offer(3, 32'h3c5a_0f01, 1'b0, 0);
    run(3, '0);
    expect_reg(OFS_RESULT, '1, 32'h3c5a_0f01);
    run(5, NB);
    expect_reg(OFS_MSR, CY, CY);
    far.offer(5, 32'h0000_a5a5, 1'b0, 0);
    run(5, NB);
    expect_reg(OFS_MSR, CY, '0);
    $display("test get and carry done");
    far.offer(7, 32'h7777_0001, 1'b1, 0);
    run(7, NB | CT);
    expect_reg(OFS_MSR, SE, '0);
    far.offer(7, 32'h7777_0002, 1'b1, 0);
    run(7, NB);
    expect_reg(OFS_MSR, SE, SE);
    xfer(OFS_MSR, 1'b1, '0);
    run(7, NB | CT);
    expect_reg(OFS_MSR, SE, '0);
    xfer(OFS_RESULT, 1'b0, '0);
    keep = rd;
    far.offer(9, 32'h9999_beef, 1'b0, 0);
    run(9, NB | CT | EX);
    expect_reg(OFS_ESR, 32'h1ff, {23'h0, 4'h9, EC_STREAM});
    expect_reg(OFS_EDR, '1, 32'h9999_beef);
    expect_reg(OFS_RESULT, '1, keep);
    $display("test tag and exception done");
    far.offer(2, 32'h2222_1234, 1'b0, 0);
    run(2, NB | TS);
    expect_reg(OFS_RESULT, '1, 32'h2222_1234);
    run(2, NB);
    expect_reg(OFS_MSR, CY, '0);
    run(2, NB);
    expect_reg(OFS_MSR, CY, CY);
    $display("test peek done");
    xfer(OFS_INDEX, 1'b1, 32'h4);
    fork
      far.offer(4, 32'h4444_0004, 1'b0, 30);
    join_none
    xfer(OFS_ISSUE, 1'b1, AT);
    irq <= 1'b1;
    expect_reg(OFS_STATUS, 32'h1 << STS_STALL, 32'h1 << STS_STALL);
    check_bit(hold, 1'b1);
    xfer(OFS_ISSUE, 1'b1, NB);
    check_bit(perr, 1'b1);
    wait_idle();
    expect_reg(OFS_RESULT, '1, 32'h4444_0004);
    expect_reg(OFS_STATUS, 32'h1 << STS_ABORT, '0);
    xfer(OFS_INDEX, 1'b1, 32'h6);
    xfer(OFS_ISSUE, 1'b1, '0);
    wait_idle();
    irq <= 1'b0;
    expect_reg(OFS_STATUS, 32'h1 << STS_ABORT, 32'h1 << STS_ABORT);
    check_bit(hold, 1'b0);
    $display("test stall done");
    far.offer(1, 32'h1111_0001, 1'b0, 0);
    xfer(OFS_MSR, 1'b1, 32'h1 << MSR_USER);
    xfer(OFS_RESULT, 1'b0, '0);
    keep = rd;
    run(1, NB);
    expect_reg(OFS_ESR, 32'h1f, {27'h0, EC_PRIV});
    expect_reg(OFS_RESULT, '1, keep);
    xfer(OFS_MSR, 1'b1, '0);
    run(1, NB);
    expect_reg(OFS_RESULT, '1, 32'h1111_0001);
    xfer(8'h1c, 1'b0, '0);
    check_bit(perr, 1'b1);
    check(rd, '0);
    check(exc_count, 32'd2);
    $display("test privilege and map done");
    conclude();
  end
endmodule
`default_nettype wire
